// File: logic/ssl_status_sources.sv
// status and event signal sources of the recorder
`timescale 1ns/100ps
// Behaviour
// RULE1 - analog fault while signal beyond threshold
// RULE2 - totalizer fault held until wrap or reset
// RULE3 - media absent and present complementary flags
// RULE4 - warn when about 300 files stored
// RULE5 - flags at 80 and 100 percent full
// RULE6 - archiving flag while archive in progress
// RULE7 - digital states from C/D or volt-free A/B
// RULE8 - BCD states from D inputs, board fitted
// RULE9 - twenty-four comms-received digital states
// RULE10 - unacked is 1, process/latch/annunciator only
// RULE11 - group is OR of assigned active alarms
// RULE12 - any-alarm from enabled active alarms
// RULE13 - new-alarm pulse on alarm activation
// RULE14 - four real-time alarms gated by enable
// RULE15 - run state while totalizer counting
// RULE16 - wrap pulse two seconds with auto-wrap
// RULE17 - wrap held until reset without auto-wrap
// RULE18 - one second pulse at intermediate count
// RULE19 - 100 ms pulse per whole count
// RULE20 - unavailable sources driven inactive
// RULE21 - all pulses timed from one tick
module ssl_status_sources #(
    parameter int unsigned TICK_DIV = ssl_pkg::TICK_CYCLES,
    parameter int unsigned NUM_TOT = ssl_pkg::TOTALIZERS,
    parameter int unsigned NUM_ALM = ssl_pkg::ALARMS
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // analog inputs: level and fault threshold, one word per input
    input wire logic [ssl_pkg::ANALOG_INPUTS*16-1:0] analogLevel,
    input wire logic [ssl_pkg::ANALOG_INPUTS*16-1:0] faultThreshold,
    input wire logic [ssl_pkg::ANALOG_INPUTS-1:0] analogFitted,
    // archive medium (asynchronous pins)
    input wire logic mediaInserted,
    input wire logic archiveBusy,
    input wire logic [15:0] mediaFileCount,
    input wire logic [6:0] mediaPercentUsed,
    // modules and digital pins
    input wire logic [ssl_pkg::MODULES-1:0] moduleFitted,
    input wire logic [1:0] voltFreeAB,
    input wire logic [ssl_pkg::DIGITAL_INPUTS-1:0] digitalPins,
    input wire logic [ssl_pkg::COMMS_DIGITALS-1:0] commsDigital,
    // alarms (same clock domain)
    input wire logic [NUM_ALM-1:0] alarmEnable,
    input wire logic [NUM_ALM-1:0] alarmActive,
    input wire logic [NUM_ALM-1:0] alarmAcked,
    input wire logic [NUM_ALM*2-1:0] alarmType,
    input wire logic [NUM_ALM*ssl_pkg::ALARM_GROUPS-1:0] groupAssign,
    input wire logic [ssl_pkg::RT_ALARMS-1:0] rtAlarmEnable,
    input wire logic [ssl_pkg::RT_ALARMS-1:0] rtAlarmActive,
    // totalizers (same clock domain)
    input wire logic [NUM_TOT-1:0] totEnable,
    input wire logic [NUM_TOT-1:0] totCounting,
    input wire logic [NUM_TOT-1:0] totFailEvent,
    input wire logic [NUM_TOT-1:0] totWrapEvent,
    input wire logic [NUM_TOT-1:0] totResetEvent,
    input wire logic [NUM_TOT-1:0] totIntermediateEvent,
    input wire logic [NUM_TOT-1:0] totWholeCountEvent,
    input wire logic [NUM_TOT-1:0] autoWrapEnable,
    // error states
    output logic [ssl_pkg::ANALOG_INPUTS-1:0] analog_input_fault,
    output logic [NUM_TOT-1:0] totalizerFault,
    output logic mediaAbsent,
    output logic mediaPresent,
    output logic tooManyFiles,
    output logic archiveFull,
    output logic archiveNearFull,
    output logic archiveOnline,
    // digital states
    output logic [ssl_pkg::DIGITAL_INPUTS-1:0] digitalState,
    output logic [ssl_pkg::BCD_STATES-1:0] decimal_coded_input_state,
    output logic [ssl_pkg::COMMS_DIGITALS-1:0] commsDigitalState,
    // alarm states
    output logic [NUM_ALM-1:0] alarmState,
    output logic [NUM_ALM-1:0] alarm_unacked_flag,
    output logic [ssl_pkg::ALARM_GROUPS-1:0] alarmGroup,
    output logic anyAlarm,
    output logic newAlarm,
    output logic [ssl_pkg::RT_ALARMS-1:0] realTimeAlarm,
    // totalizer states and pulses
    output logic [NUM_TOT-1:0] runState,
    output logic [NUM_TOT-1:0] wrapPulse,
    output logic [NUM_TOT-1:0] intermediate_count_pulse,
    output logic [NUM_TOT-1:0] countPulse
);
    import ssl_pkg::*;

    localparam int unsigned A_N = ANALOG_INPUTS;
    localparam int unsigned D_N = DIGITAL_INPUTS;
    localparam int unsigned C_N = COMMS_DIGITALS;
    localparam int unsigned G_N = ALARM_GROUPS;
    localparam int unsigned R_N = RT_ALARMS;
    localparam int unsigned B_N = BCD_STATES;
    localparam int unsigned DIV_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
    localparam int unsigned POS_D = 3;
    localparam int unsigned SYNC_W = 2 + 16 + 7 + D_N + C_N;

    typedef struct packed {
        logic [DIV_W-1:0] divCount;
        logic tick;
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        logic [A_N-1:0] anaFault;
        logic [NUM_TOT-1:0] totFault;
        logic mAbsent;
        logic mPresent;
        logic manyFiles;
        logic full;
        logic nearFull;
        logic online;
        logic [D_N-1:0] digState;
        logic [B_N-1:0] bcdState;
        logic [C_N-1:0] commsState;
        logic [NUM_ALM-1:0] almState;
        logic [NUM_ALM-1:0] almUnacked;
        logic [G_N-1:0] groups;
        logic anyAlm;
        logic newAlm;
        logic [R_N-1:0] rtAlm;
        logic [NUM_TOT-1:0] run;
        logic [NUM_TOT-1:0] wrapHeld;
    } ssl_state_t;

    ssl_state_t state_r;
    ssl_state_t state_nxt;

    logic [NUM_TOT-1:0] wrapTimed;
    logic [NUM_TOT-1:0] stageTimed;
    logic [NUM_TOT-1:0] countTimed;
    logic [SYNC_W-1:0] syncIn;
    logic syncInserted;
    logic syncBusy;
    logic [15:0] syncFiles;
    logic [6:0] syncPercent;
    logic [D_N-1:0] syncDig;
    logic [C_N-1:0] syncComms;

    initial begin
        if (TICK_DIV < 1) $error("tick divider must be at least one");
        if (NUM_TOT < 1 || NUM_ALM < 1) $error("need at least one totalizer and alarm");
    end

    // process, latch and annunciator types carry an acknowledge state
    function automatic logic ackApplies(input logic [1:0] kind);
        ackApplies = (kind != 2'(SSL_ALM_OTHER));
    endfunction

    // limitation: file count and percentage cross bit by bit, so a word caught
    // mid-change may read wrong for one cycle; the source must hold it steady
    // for a few cycles, which a slow archive status always does
    // all asynchronous inputs travel through one two-stage synchroniser
    assign syncIn = {mediaInserted, archiveBusy, mediaFileCount, mediaPercentUsed,
                     digitalPins, commsDigital};
    assign {syncInserted, syncBusy, syncFiles, syncPercent, syncDig, syncComms} = state_r.sync2;

    always_comb begin
        state_nxt = state_r;
        state_nxt.sync1 = syncIn;
        state_nxt.sync2 = state_r.sync1;
        // common tick so every channel's pulses share one time base
        state_nxt.tick = 1'b0; // RULE21
        if (state_r.divCount >= DIV_W'(TICK_DIV - 1)) begin
            state_nxt.divCount = '0;
            state_nxt.tick = 1'b1; // RULE21
        end else begin
            state_nxt.divCount = state_r.divCount + DIV_W'(1);
        end
        // analog fault compare, unfitted inputs read as ok
        for (int i = 0; i < A_N; i++) begin
            state_nxt.anaFault[i] = analogFitted[i] &&
                (analogLevel[i*16 +: 16] > faultThreshold[i*16 +: 16]); // RULE1 RULE20
        end
        // totalizer fault: set beats a simultaneous clear
        for (int t = 0; t < NUM_TOT; t++) begin
            if (!totEnable[t]) begin
                state_nxt.totFault[t] = 1'b0; // RULE20
            end else if (totFailEvent[t]) begin
                state_nxt.totFault[t] = 1'b1; // RULE2
            end else if (totWrapEvent[t] || totResetEvent[t]) begin
                state_nxt.totFault[t] = 1'b0; // RULE2
            end
            state_nxt.run[t] = totEnable[t] && totCounting[t]; // RULE15 RULE20
            // held wrap only when auto-wrap is off; reset ends it
            if (!totEnable[t] || autoWrapEnable[t]) begin
                state_nxt.wrapHeld[t] = 1'b0;
            end else if (totWrapEvent[t]) begin
                state_nxt.wrapHeld[t] = 1'b1; // RULE17
            end else if (totResetEvent[t]) begin
                state_nxt.wrapHeld[t] = 1'b0; // RULE17
            end
        end
        // archive medium flags; capacity flags meaningless with no medium
        state_nxt.mAbsent = !syncInserted; // RULE3
        state_nxt.mPresent = syncInserted; // RULE3
        state_nxt.manyFiles = syncInserted && (syncFiles >= 16'(FILE_WARN_COUNT)); // RULE4
        state_nxt.full = syncInserted && (syncPercent >= 7'(FULL_PERCENT)); // RULE5
        state_nxt.nearFull = syncInserted && (syncPercent >= 7'(NEAR_FULL_PERCENT)); // RULE5
        state_nxt.online = syncInserted && syncBusy; // RULE6
        // digital states: C and D hybrid boards, A and B only when volt-free
        for (int m = 0; m < MODULES; m++) begin
            for (int b = 0; b < DIG_PER_MODULE; b++) begin
                state_nxt.digState[m*DIG_PER_MODULE + b] = moduleFitted[m] &&
                    (m >= 2 || voltFreeAB[m]) && syncDig[m*DIG_PER_MODULE + b]; // RULE7 RULE20
            end
        end
        // one-hot decimal state from the low five inputs of board D
        state_nxt.bcdState = '0;
        if (moduleFitted[POS_D]) begin
            state_nxt.bcdState[syncDig[POS_D*DIG_PER_MODULE +: 5]] = 1'b1; // RULE8
        end
        state_nxt.commsState = syncComms; // RULE9
        // alarm states, acknowledge and groups
        state_nxt.anyAlm = 1'b0;
        state_nxt.newAlm = 1'b0;
        state_nxt.groups = '0;
        for (int a = 0; a < NUM_ALM; a++) begin
            state_nxt.almState[a] = alarmEnable[a] && alarmActive[a]; // RULE20
            state_nxt.almUnacked[a] = alarmEnable[a] && alarmActive[a] && !alarmAcked[a] &&
                ackApplies(alarmType[a*2 +: 2]); // RULE10
            if (state_nxt.almState[a]) begin
                state_nxt.anyAlm = 1'b1; // RULE12
                if (!state_r.almState[a]) begin
                    state_nxt.newAlm = 1'b1; // RULE13
                end
                for (int g = 0; g < G_N; g++) begin
                    if (groupAssign[a*G_N + g]) begin
                        state_nxt.groups[g] = 1'b1; // RULE11
                    end
                end
            end
        end
        state_nxt.rtAlm = rtAlarmEnable & rtAlarmActive; // RULE14
    end

    // medium reads absent in reset, so no consumer sees a phantom card
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_r <= '0;
            state_r.mAbsent <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    // per-totalizer pulse timers driven by the common tick
    for (genvar t = 0; t < NUM_TOT; t++) begin : gTot
        ssl_pulse_timer #(.WIDTH(PULSE_W)) uWrap (
            .core_clk(core_clk),
            .reset(reset),
            .tickEn(state_r.tick),
            .trigger(totEnable[t] && autoWrapEnable[t] && totWrapEvent[t]), // RULE16
            .clear(!totEnable[t] || totResetEvent[t]),
            .lengthTicks(PULSE_W'(WRAP_TICKS)), // RULE16
            .pulseOut(wrapTimed[t])
        );
        ssl_pulse_timer #(.WIDTH(PULSE_W)) uStage (
            .core_clk(core_clk),
            .reset(reset),
            .tickEn(state_r.tick),
            .trigger(totEnable[t] && totIntermediateEvent[t]), // RULE18
            .clear(!totEnable[t]),
            .lengthTicks(PULSE_W'(STAGE_TICKS)), // RULE18
            .pulseOut(stageTimed[t])
        );
        ssl_pulse_timer #(.WIDTH(PULSE_W)) uCount (
            .core_clk(core_clk),
            .reset(reset),
            .tickEn(state_r.tick),
            .trigger(totEnable[t] && totWholeCountEvent[t]), // RULE19
            .clear(!totEnable[t]),
            .lengthTicks(PULSE_W'(COUNT_TICKS)), // RULE19
            .pulseOut(countTimed[t])
        );
    end

    // outputs straight from flip-flops; timers gated off when disabled
    assign analog_input_fault = state_r.anaFault;
    assign totalizerFault = state_r.totFault;
    assign mediaAbsent = state_r.mAbsent;
    assign mediaPresent = state_r.mPresent;
    assign tooManyFiles = state_r.manyFiles;
    assign archiveFull = state_r.full;
    assign archiveNearFull = state_r.nearFull;
    assign archiveOnline = state_r.online;
    assign digitalState = state_r.digState;
    assign decimal_coded_input_state = state_r.bcdState;
    assign commsDigitalState = state_r.commsState;
    assign alarmState = state_r.almState;
    assign alarm_unacked_flag = state_r.almUnacked;
    assign alarmGroup = state_r.groups;
    assign anyAlarm = state_r.anyAlm;
    assign newAlarm = state_r.newAlm;
    assign realTimeAlarm = state_r.rtAlm;
    assign runState = state_r.run;
    assign wrapPulse = (wrapTimed | state_r.wrapHeld) & totEnable; // RULE20
    assign intermediate_count_pulse = stageTimed & totEnable;
    assign countPulse = countTimed & totEnable;
endmodule // ssl_status_sources

// File: logic/ssl_pkg.sv
// package of constants and types for the status signal source logic
package ssl_pkg;
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned ANALOG_INPUTS = 12;
    localparam int unsigned TOTALIZERS = 12;
    localparam int unsigned ALARMS = 24;
    localparam int unsigned ALARM_GROUPS = 12;
    localparam int unsigned RT_ALARMS = 4;
    localparam int unsigned COMMS_DIGITALS = 24;
    localparam int unsigned DIG_PER_MODULE = 6;
    localparam int unsigned MODULES = 4;
    localparam int unsigned DIGITAL_INPUTS = DIG_PER_MODULE * MODULES;
    localparam int unsigned BCD_STATES = 32;
    // archive thresholds
    localparam int unsigned FILE_WARN_COUNT = 300;
    localparam int unsigned FULL_PERCENT = 100;
    localparam int unsigned NEAR_FULL_PERCENT = 80;
    // pulse times in milliseconds and the tick that times them
    localparam int unsigned TICK_MS = 100;
    localparam int unsigned WRAP_PULSE_MS = 2000;
    localparam int unsigned STAGE_PULSE_MS = 1000;
    localparam int unsigned COUNT_PULSE_MS = 100;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned WRAP_TICKS = WRAP_PULSE_MS / TICK_MS;
    localparam int unsigned STAGE_TICKS = STAGE_PULSE_MS / TICK_MS;
    localparam int unsigned COUNT_TICKS = COUNT_PULSE_MS / TICK_MS;
    localparam int unsigned PULSE_W = 5;
    // alarm type codes
    typedef enum logic [1:0] {SSL_ALM_PROCESS, SSL_ALM_LATCH, SSL_ALM_ANNUN, SSL_ALM_OTHER}
        ssl_alarm_type_t;
endpackage

// File: logic/ssl_pulse_timer.sv
// retriggerable pulse stretcher counting common ticks
`timescale 1ns/100ps
module ssl_pulse_timer #(
    parameter int unsigned WIDTH = 5
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // control
    input wire logic tickEn,
    input wire logic trigger,
    input wire logic clear,
    input wire logic [WIDTH-1:0] lengthTicks,
    // output
    output logic pulseOut
);
    import ssl_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] remain;
        logic active;
    } ssl_pt_state_t;

    ssl_pt_state_t state_r;
    ssl_pt_state_t state_nxt;

    initial begin
        if (WIDTH < 1) $error("pulse timer width must be at least one");
    end

    // a trigger restarts the count, so close events merge into one longer pulse
    always_comb begin
        state_nxt = state_r;
        if (clear) begin
            state_nxt.remain = '0;
            state_nxt.active = 1'b0;
        end else if (trigger) begin
            state_nxt.remain = lengthTicks;
            state_nxt.active = 1'b1;
        end else if (tickEn && state_r.active) begin
            if (state_r.remain <= WIDTH'(1)) begin
                state_nxt.remain = '0;
                state_nxt.active = 1'b0;
            end else begin
                state_nxt.remain = state_r.remain - WIDTH'(1);
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign pulseOut = state_r.active;
endmodule // ssl_pulse_timer

// File: sim/ssl_status_props.sv
// concurrent checks on the status signal sources ports
`timescale 1ns/100ps
module ssl_status_props #(
    parameter int unsigned NUM_TOT = 12,
    parameter int unsigned NUM_ALM = 24
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // watched inputs
    input wire logic [ssl_pkg::ANALOG_INPUTS*16-1:0] analogLevel,
    input wire logic [ssl_pkg::ANALOG_INPUTS*16-1:0] faultThreshold,
    input wire logic [ssl_pkg::ANALOG_INPUTS-1:0] analogFitted,
    input wire logic [NUM_ALM-1:0] alarmEnable,
    input wire logic [NUM_ALM-1:0] alarmActive,
    input wire logic [NUM_ALM-1:0] alarmAcked,
    input wire logic [NUM_ALM*2-1:0] alarmType,
    input wire logic [ssl_pkg::RT_ALARMS-1:0] rtAlarmEnable,
    input wire logic [ssl_pkg::RT_ALARMS-1:0] rtAlarmActive,
    input wire logic [NUM_TOT-1:0] totEnable,
    input wire logic [NUM_TOT-1:0] totCounting,
    // watched outputs
    input wire logic [ssl_pkg::ANALOG_INPUTS-1:0] analog_input_fault,
    input wire logic mediaAbsent,
    input wire logic mediaPresent,
    input wire logic tooManyFiles,
    input wire logic archiveFull,
    input wire logic archiveNearFull,
    input wire logic archiveOnline,
    input wire logic [NUM_ALM-1:0] alarmState,
    input wire logic [NUM_ALM-1:0] alarm_unacked_flag,
    input wire logic anyAlarm,
    input wire logic newAlarm,
    input wire logic [ssl_pkg::RT_ALARMS-1:0] realTimeAlarm,
    input wire logic [NUM_TOT-1:0] runState
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    // level outputs follow their causes one edge later; first edge after reset skipped
    property p_anyAlarm;
        !$past(reset) |-> anyAlarm == |($past(alarmEnable) & $past(alarmActive));
    endproperty
    a_anyAlarm: assert property (p_anyAlarm) else $error("any alarm wrong");
    property p_newAlarm;
        !$past(reset) |-> newAlarm == |(alarmState & ~$past(alarmState));
    endproperty
    a_newAlarm: assert property (p_newAlarm) else $error("new alarm wrong");
    property p_realTime;
        !$past(reset) |-> realTimeAlarm == ($past(rtAlarmEnable) & $past(rtAlarmActive));
    endproperty
    a_realTime: assert property (p_realTime) else $error("real time alarm wrong");
    property p_runState;
        !$past(reset) |-> runState == ($past(totEnable) & $past(totCounting));
    endproperty
    a_runState: assert property (p_runState) else $error("run state wrong");
    property p_unacked;
        !$past(reset) |-> alarm_unacked_flag[0] == ($past(alarmEnable[0])
            && $past(alarmActive[0]) && !$past(alarmAcked[0]) && $past(alarmType[1:0]) != 2'h3);
    endproperty
    a_unacked: assert property (p_unacked) else $error("unacked flag wrong");
    property p_analogFault;
        !$past(reset) |-> analog_input_fault[0] == ($past(analogFitted[0])
            && $past(analogLevel[15:0]) > $past(faultThreshold[15:0]));
    endproperty
    a_analogFault: assert property (p_analogFault) else $error("analog fault wrong");
    property p_mediaPair;
        mediaAbsent != mediaPresent;
    endproperty
    a_mediaPair: assert property (p_mediaPair) else $error("media pair wrong");
    // capacity and activity flags mean nothing without a medium
    property p_archiveFlags;
        (tooManyFiles || archiveFull || archiveNearFull || archiveOnline) |-> mediaPresent;
    endproperty
    a_archiveFlags: assert property (p_archiveFlags) else $error("flag without medium");
endmodule // ssl_status_props

bind ssl_status_sources ssl_status_props #(.NUM_TOT(NUM_TOT), .NUM_ALM(NUM_ALM)) i_props (.*);

// File: sim/testbench.sv
// self-checking bench for the status signal sources
`timescale 1ns/100ps
module testbench;
    import ssl_pkg::*;
    localparam int unsigned TD = 4; // short tick keeps pulse runs brief
    // design inputs
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [191:0] analogLevel = '0, faultThreshold = '0;
    logic [287:0] groupAssign = '0;
    logic [47:0] alarmType = '0;
    logic [23:0] digitalPins = '0, commsDigital = '0, alarmEnable = '0, alarmActive = '0;
    logic [23:0] alarmAcked = '0;
    logic [15:0] mediaFileCount = '0;
    logic [11:0] analogFitted = '0, totEnable = '0, totCounting = '0, autoWrapEnable = '0;
    logic [11:0] totFailEvent = '0, totWrapEvent = '0, totResetEvent = '0;
    logic [11:0] totIntermediateEvent = '0, totWholeCountEvent = '0;
    logic [6:0] mediaPercentUsed = '0;
    logic [3:0] moduleFitted = '0, rtAlarmEnable = '0, rtAlarmActive = '0;
    logic [1:0] voltFreeAB = '0;
    logic mediaInserted = 1'b0, archiveBusy = 1'b0;
    // design outputs
    logic [31:0] decimal_coded_input_state;
    logic [23:0] digitalState, commsDigitalState, alarmState, alarm_unacked_flag;
    logic [11:0] analog_input_fault, totalizerFault, alarmGroup, runState, wrapPulse;
    logic [11:0] intermediate_count_pulse, countPulse;
    logic [3:0] realTimeAlarm;
    logic mediaAbsent, mediaPresent, tooManyFiles, archiveFull, archiveNearFull, archiveOnline;
    logic anyAlarm, newAlarm;
    logic [31:0] seed = 32'h0000188F;
    int nErrors = 0, checksDone = 0;

    ssl_status_sources #(.TICK_DIV(TD)) i_ssl_status_sources (.*);

    // free-running core clock
    always #2 core_clk = ~core_clk;

    // xorshift source, fixed start so runs repeat
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nErrors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // verdict and end of run
    task automatic end_of_test();
        if (nErrors == 0 && checksDone > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // expected values
    function automatic logic [11:0] expFault(logic [191:0] l, logic [191:0] t, logic [11:0] f);
        for (int i = 0; i < 12; i++) expFault[i] = f[i] && l[i*16+:16] > t[i*16+:16];
    endfunction
    function automatic logic [11:0] expGroup(logic [23:0] st, logic [287:0] ga);
        logic [11:0] g = '0;
        for (int a = 0; a < 24; a++) g |= st[a] ? ga[a*12+:12] : 12'h000;
        return g;
    endfunction
    function automatic logic [23:0] expUnack(logic [23:0] st, logic [23:0] ak, logic [47:0] ty);
        for (int a = 0; a < 24; a++) expUnack[a] = st[a] && !ak[a] && ty[a*2+:2] != 2'h3;
    endfunction
    function automatic logic [23:0] expDig(logic [3:0] fit, logic [1:0] vf, logic [23:0] p);
        for (int m = 0; m < 4; m++) expDig[m*6+:6] = (fit[m] && (m > 1 || vf[m])) ? p[m*6+:6] : 6'h00;
    endfunction
    function automatic logic pulseBit(int kind);
        return kind == 0 ? countPulse[0] : kind == 1 ? intermediate_count_pulse[0] : wrapPulse[0];
    endfunction

    // every input random each cycle; same-clock outputs judged one edge on
    task automatic randomPhase(input int n);
        logic [991:0] w;
        logic [23:0] st, eUn;
        logic [11:0] eFault, eGrp, eRun;
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            st = alarmEnable & alarmActive;
            eUn = expUnack(st, alarmAcked, alarmType);
            eFault = expFault(analogLevel, faultThreshold, analogFitted);
            eGrp = expGroup(st, groupAssign);
            eRun = totEnable & totCounting;
            for (int k = 0; k < 31; k++) w[k*32+:32] = rnd();
            {analogLevel, faultThreshold, groupAssign, analogFitted, mediaInserted, archiveBusy,
                mediaFileCount, mediaPercentUsed, moduleFitted, voltFreeAB, digitalPins,
                commsDigital, alarmEnable, alarmActive, alarmAcked, alarmType, rtAlarmEnable,
                rtAlarmActive, totEnable, totCounting, totFailEvent, totWrapEvent, totResetEvent,
                totIntermediateEvent, totWholeCountEvent, autoWrapEnable} <= w[986:0];
            @(negedge core_clk);
            check("unacked", 32'(alarm_unacked_flag), 32'(eUn));
            check("alarm state", 32'(alarmState), 32'(st));
            check("group", 32'(alarmGroup), 32'(eGrp));
            check("any alarm", 32'(anyAlarm), 32'(|st));
            check("analog fault", 32'(analog_input_fault), 32'(eFault));
            check("run state", 32'(runState), 32'(eRun));
        end
    endtask

    // held pin patterns; the synchroniser needs three edges to settle
    task automatic digPhase();
        logic [31:0] e;
        for (int i = 0; i < 12; i++) begin
            @(posedge core_clk);
            {moduleFitted, voltFreeAB, digitalPins} <= i == 0 ? 30'h3FFFFFFF : i == 1 ? 30'h0 : 30'(rnd());
            commsDigital <= 24'(rnd());
            repeat (4) @(posedge core_clk);
            @(negedge core_clk);
            e = moduleFitted[3] ? 32'h1 << digitalPins[22:18] : 32'h0;
            check("digital", 32'(digitalState), 32'(expDig(moduleFitted, voltFreeAB, digitalPins)));
            check("comms", 32'(commsDigitalState), 32'(commsDigital));
            check("decimal", decimal_coded_input_state, e);
        end
    endtask

    // archive medium levels, flags read once synchronised
    task automatic mediaCase(input logic [24:0] lv, input logic [5:0] exp);
        logic [5:0] f;
        @(posedge core_clk);
        {mediaInserted, archiveBusy, mediaFileCount, mediaPercentUsed} <= lv;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        f = {mediaAbsent, mediaPresent, tooManyFiles, archiveFull, archiveNearFull, archiveOnline};
        check("archive flags", 32'(f), 32'(exp));
    endtask

    // one-cycle event on totalizer 0: 0 count, 1 stage, 2 wrap, 3 reset, 4 fail
    task automatic fire(input int which);
        @(posedge core_clk);
        {totWholeCountEvent, totIntermediateEvent, totWrapEvent, totResetEvent, totFailEvent}
            <= 60'h1 << (12 * (4 - which));
        @(posedge core_clk);
        {totWholeCountEvent, totIntermediateEvent, totWrapEvent, totResetEvent, totFailEvent} <= '0;
        @(negedge core_clk);
    endtask

    // stretched width must land inside the tick window of n ticks
    task automatic pulseLen(input int kind, input int n);
        int len = 0;
        fire(kind);
        while (len < 200 && pulseBit(kind) === 1'b1) begin
            len++;
            @(negedge core_clk);
        end
        if (len == 200) begin
            nErrors++;
            end_of_test();
        end
        check("pulse width", 32'(len > (n - 1) * TD && len <= n * TD), 32'h1);
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        randomPhase(600);
        digPhase();
        mediaCase({1'h0, 1'h1, 16'h0190, 7'h64}, 6'h20);
        mediaCase({1'h1, 1'h0, 16'h012B, 7'h4F}, 6'h10);
        mediaCase({1'h1, 1'h1, 16'h012C, 7'h50}, 6'h1B);
        mediaCase({1'h1, 1'h1, 16'h012C, 7'h64}, 6'h1F);
        @(posedge core_clk);
        {totEnable, autoWrapEnable} <= {12'h001, 12'h001};
        fire(3);
        repeat (100) @(posedge core_clk); // leftover random pulses run out
        pulseLen(0, COUNT_TICKS);
        pulseLen(1, STAGE_TICKS);
        pulseLen(2, WRAP_TICKS);
        @(posedge core_clk);
        autoWrapEnable <= 12'h000;
        fire(2);
        repeat (100) @(negedge core_clk);
        check("held wrap", 32'(wrapPulse[0]), 32'h1);
        fire(3);
        check("wrap released", 32'(wrapPulse[0]), 32'h0);
        fire(4);
        check("fault set", 32'(totalizerFault[0]), 32'h1);
        fire(2);
        check("fault on wrap", 32'(totalizerFault[0]), 32'h0);
        fire(4);
        fire(3);
        check("fault on reset", 32'(totalizerFault[0]), 32'h0);
        @(posedge core_clk);
        totEnable <= 12'h000;
        fire(4);
        check("fault disabled", 32'(totalizerFault[0]), 32'h0);
        fire(0);
        check("count disabled", 32'(countPulse[0]), 32'h0);
        end_of_test();
    end
endmodule // testbench
